// ---- src/pointer_pitch_quantizer.sv ----
// Top of the pointer pitch quantizer: mode counter, quantization paths, output stage
// and a small register port.
// Assumes buttons and coordinates come from same-clock logic, valid with update.
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module pointer_pitch_quantizer
  import pitch_quant_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        update,
  input  wire logic [7:0]  buttons,
  input  wire logic [15:0] abs_x,
  input  wire logic [15:0] abs_y,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic      [15:0] pitch_conv_one,
  output logic      [15:0] pitch_conv_two,
  output logic             conv_strobe,
  output logic             gate_left,
  output logic             gate_right,
  output logic             lamp_left_on,
  output logic             lamp_left_red,
  output logic             lamp_right_on,
  output logic             lamp_right_red
);

  //////////////////////////////////////////////////////////////////////////////
  // State

  logic [7:0]  prev_buttons_q;
  logic [7:0]  prev_buttons_d;
  logic [1:0]  mode_q;
  logic [1:0]  mode_d;
  logic [15:0] out_pitch_x_q;
  logic [15:0] out_pitch_x_d;
  logic [15:0] out_pitch_y_q;
  logic [15:0] out_pitch_y_d;
  logic        strobe_q;
  logic        strobe_d;
  panel_type   panel_q;
  panel_type   panel_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [3:0]  rel_degree_x_q;
  logic [3:0]  rel_degree_x_d;
  logic [3:0]  rel_degree_y_q;
  logic [3:0]  rel_degree_y_d;

  //////////////////////////////////////////////////////////////////////////////
  // Button edges and mode

  logic        press_left;
  logic        press_right;
  logic        press_middle;
  logic [1:0]  mode_now;

  always_comb begin
    press_left   = update && buttons[btn_left_bit] && !prev_buttons_q[btn_left_bit];
    press_right  = update && buttons[btn_right_bit] && !prev_buttons_q[btn_right_bit];
    press_middle = update && buttons[btn_middle_bit] && !prev_buttons_q[btn_middle_bit];
    prev_buttons_d = update ? buttons : prev_buttons_q;
    mode_d = mode_q;
    if (reg_wr && reg_addr == addr_mode) begin
      mode_d = reg_wdata[1:0];
    end
    // A middle click in the same cycle as a software write still counts
    if (press_middle) begin // R1
      mode_d = mode_d + 2'h1;
    end
    // The new mode already governs the report that changed it
    mode_now = press_middle ? mode_q + 2'h1 : mode_q;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Quantization paths

  logic [15:0] semi_x;
  logic [15:0] semi_y;
  logic [15:0] key_q;
  logic [15:0] key_used;
  logic [2:0]  fourths_q;
  logic [2:0]  sevenths_q;
  logic [15:0] snap_x;
  logic [15:0] snap_y;
  logic [3:0]  degree_x;
  logic [3:0]  degree_y;

  always_comb begin
    semi_x = semitone_round(abs_x); // R2
    semi_y = semitone_round(abs_y); // R2
    // Fixed-key mode quantizes against a zero key in this same pass
    key_used = (mode_now == mode_fixed_key) ? key_reset : key_q; // R15 R5
  end

  scale_snap snap_x_i (
    .semi_pitch (semi_x),
    .raw_pitch  (abs_x),
    .key        (key_used),
    .snapped    (snap_x),
    .rel_degree (degree_x)
  );

  scale_snap snap_y_i (
    .semi_pitch (semi_y),
    .raw_pitch  (abs_y),
    .key        (key_used),
    .snapped    (snap_y),
    .rel_degree (degree_y)
  );

  streak_key streak_i (
    .clk         (clk),
    .rst_n       (rst_n),
    .update      (update),
    .mode        (mode_now),
    .press_left  (press_left),
    .press_right (press_right),
    .degree_x    (degree_x),
    .degree_y    (degree_y),
    .key_q       (key_q),
    .fourths_q   (fourths_q),
    .sevenths_q  (sevenths_q)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Output stage

  always_comb begin
    out_pitch_x_d  = out_pitch_x_q;
    out_pitch_y_d  = out_pitch_y_q;
    rel_degree_x_d = rel_degree_x_q;
    rel_degree_y_d = rel_degree_y_q;
    panel_d        = panel_q;
    strobe_d       = update; // R21
    if (update) begin
      case (mode_now)
        mode_adaptive, mode_fixed_key: begin
          out_pitch_x_d = snap_x;
          out_pitch_y_d = snap_y;
        end
        mode_semitone: begin // R16
          out_pitch_x_d = semi_x;
          out_pitch_y_d = semi_y;
        end
        default: begin // R16
          out_pitch_x_d = abs_x;
          out_pitch_y_d = abs_y;
        end
      endcase
      // Released buttons give the raw glide whatever the mode
      if (!buttons[btn_left_bit]) begin // R19
        out_pitch_x_d = abs_x;
      end
      if (!buttons[btn_right_bit]) begin // R20
        out_pitch_y_d = abs_y;
      end
      rel_degree_x_d        = degree_x; // R9
      rel_degree_y_d        = degree_y; // R9
      panel_d.lamp_left_red  = !mode_now[1]; // R3
      panel_d.lamp_right_red = !mode_now[0]; // R3
      panel_d.gate_left      = buttons[btn_left_bit]; // R17 R4
      panel_d.gate_right     = buttons[btn_right_bit]; // R20
      panel_d.lamp_left_on   = buttons[btn_left_bit] | buttons[btn_middle_bit]; // R18
      panel_d.lamp_right_on  = buttons[btn_right_bit]; // R20
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register port

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_rd) begin
      if (reg_addr == addr_mode) begin
        rdata_d = {30'h0, mode_q};
      end else if (reg_addr == addr_status) begin
        rdata_d = {8'h00, 1'b0, sevenths_q, 1'b0, fourths_q, key_q};
      end else if (reg_addr == addr_degrees) begin
        rdata_d = {16'h0000, 4'h0, rel_degree_y_q, 4'h0, rel_degree_x_q};
      end else begin
        rdata_d = 32'h0000_0000;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_buttons_q <= 8'h00;
      mode_q         <= mode_reset; // R22
      out_pitch_x_q  <= 16'h0000;
      out_pitch_y_q  <= 16'h0000;
      rel_degree_x_q <= 4'h0;
      rel_degree_y_q <= 4'h0;
      strobe_q       <= 1'b0;
      panel_q        <= '0;
      rdata_q        <= 32'h0000_0000;
    end else begin
      prev_buttons_q <= prev_buttons_d;
      mode_q         <= mode_d;
      out_pitch_x_q  <= out_pitch_x_d;
      out_pitch_y_q  <= out_pitch_y_d;
      rel_degree_x_q <= rel_degree_x_d;
      rel_degree_y_q <= rel_degree_y_d;
      strobe_q       <= strobe_d;
      panel_q        <= panel_d;
      rdata_q        <= rdata_d;
    end
  end

  always_comb begin
    pitch_conv_one = out_pitch_x_q; // R21
    pitch_conv_two = out_pitch_y_q; // R21
    conv_strobe    = strobe_q;
    gate_left      = panel_q.gate_left;
    gate_right     = panel_q.gate_right;
    lamp_left_on   = panel_q.lamp_left_on;
    lamp_left_red  = panel_q.lamp_left_red;
    lamp_right_on  = panel_q.lamp_right_on;
    lamp_right_red = panel_q.lamp_right_red;
    reg_rdata      = rdata_q;
  end

endmodule
`default_nettype wire

// ---- pkg/pitch_quant_pkg.sv ----
// Constants, types and shared arithmetic for the pointer pitch quantizer.
// Assumes pitches in semitone-and-fraction form: high byte note, low byte 1/256 semitone.
//
// Overview of operation
// [R1] Middle button rising edge advances mode, starts three
// [R2] Semitone pitch: add half semitone, clear low byte
// [R3] Left lamp red modes 0-1; right by bit0
// [R4] Buttons: left bit0, right bit1, middle bit2
// [R5] Key offset whole semitones, negative of root
// [R6] Pitch plus key modulo octave gives position
// [R7] Major mask membership; in-scale pitch kept
// [R8] Out-of-scale: step opposite the rounding direction
// [R9] Relative degree 0..11 per axis, scale degrees only
// [R10] Adaptive: left press, degree five counts fourths
// [R11] Adaptive: left press, degree eleven counts sevenths
// [R12] Right press counts same pair via Y
// [R13] Streak three shifts key seven or five
// [R14] Key reduced modulo octave after each shift
// [R15] Fixed mode: key zero, counters cleared
// [R16] Mode two semitone, mode three unquantized
// [R17] Left gate follows button one
// [R18] Left lamp lit by button one or three
// [R19] Released left button gives unquantized X pitch
// [R20] Right side mirrors with button two, Y
// [R21] Each update sends X, Y to converters
// [R22] Reset clears key, counters; mode to three
package pitch_quant_pkg;

  localparam logic [15:0] half_semitone   = 16'h0080;
  localparam logic [15:0] one_semitone    = 16'h0100;
  localparam logic [15:0] one_octave      = 16'h0c00;
  localparam logic [15:0] shift_subdom    = 16'h0700;
  localparam logic [15:0] shift_dominant  = 16'h0500;
  localparam logic [11:0] major_mask      = 12'had5;
  localparam logic [3:0]  degree_fourth   = 4'h5;
  localparam logic [3:0]  degree_seventh  = 4'hb;
  localparam logic [2:0]  streak_len      = 3'h3;
  localparam logic [1:0]  mode_reset      = 2'h3;
  localparam logic [15:0] key_reset       = 16'h0000;
  localparam int          btn_left_bit    = 0;
  localparam int          btn_right_bit   = 1;
  localparam int          btn_middle_bit  = 2;

  // Register port map, word addresses
  localparam logic [3:0]  addr_mode       = 4'h0;
  localparam logic [3:0]  addr_status     = 4'h4;
  localparam logic [3:0]  addr_degrees    = 4'h8;

  typedef enum logic [1:0] {
    mode_adaptive  = 2'b00,
    mode_fixed_key = 2'b01,
    mode_semitone  = 2'b10,
    mode_raw       = 2'b11
  } quant_mode_type;

  typedef struct packed {
    logic gate_left;
    logic gate_right;
    logic lamp_left_on;
    logic lamp_left_red;
    logic lamp_right_on;
    logic lamp_right_red;
  } panel_type;

  // Unsigned 16-bit remainder by one octave
  function automatic logic [15:0] octave_remainder(input logic [15:0] v);
    octave_remainder = v % one_octave;
  endfunction

  function automatic logic [15:0] semitone_round(input logic [15:0] v);
    logic [15:0] s;
    s = v + half_semitone;
    semitone_round = {s[15:8], 8'h00};
  endfunction

endpackage

// ---- src/scale_snap.sv ----
// Snaps a semitone-rounded pitch onto the major scale of the given key.
// Assumes a purely combinational context; the caller registers the result.
`timescale 1ns/10ps
`default_nettype none
module scale_snap
  import pitch_quant_pkg::*;
(
  input  wire logic [15:0] semi_pitch,
  input  wire logic [15:0] raw_pitch,
  input  wire logic [15:0] key,
  output logic      [15:0] snapped,
  output logic      [3:0]  rel_degree
);

  logic [15:0] pos_word;
  logic [3:0]  pos;

  always_comb begin
    pos_word = octave_remainder(semi_pitch + key); // R6
    pos      = pos_word[11:8];
    // The mask is stored root-last: bit 11 answers for the root, so degree i reads bit 11-i.
    // Read the other way round the set would hold degree 6 and lose degree 5.
    if (major_mask[4'hb - pos]) begin // R7
      snapped    = semi_pitch;
      rel_degree = pos; // R9
    end else if (semi_pitch > raw_pitch) begin // R8
      // Rounded up, so step back down
      snapped    = semi_pitch - one_semitone;
      rel_degree = (pos == 4'h0) ? 4'hb : pos - 4'h1;
    end else begin
      // Every off-scale note has scale neighbours, so one step suffices
      snapped    = semi_pitch + one_semitone;
      rel_degree = (pos == 4'hb) ? 4'h0 : pos + 4'h1;
    end
  end

endmodule
`default_nettype wire

// ---- src/streak_key.sv ----
// Fourths and sevenths streak counters and the adaptive key offset.
// Assumes new-press flags and degrees are valid in the update cycle.
`timescale 1ns/10ps
`default_nettype none
module streak_key
  import pitch_quant_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        update,
  input  wire logic [1:0]  mode,
  input  wire logic        press_left,
  input  wire logic        press_right,
  input  wire logic [3:0]  degree_x,
  input  wire logic [3:0]  degree_y,
  output logic      [15:0] key_q,
  output logic      [2:0]  fourths_q,
  output logic      [2:0]  sevenths_q
);

  logic [15:0] key_d;
  logic [2:0]  fourths_d;
  logic [2:0]  sevenths_d;

  always_comb begin
    key_d      = key_q;
    fourths_d  = fourths_q;
    sevenths_d = sevenths_q;
    if (update && mode == mode_adaptive) begin
      // X press counted before Y press, one shared pair
      if (press_left && degree_x == degree_fourth) begin // R10
        fourths_d  = fourths_d + 3'h1;
        sevenths_d = 3'h0;
      end else if (press_left && degree_x == degree_seventh) begin // R11
        sevenths_d = sevenths_d + 3'h1;
        fourths_d  = 3'h0;
      end
      if (press_right && degree_y == degree_fourth) begin // R12
        fourths_d  = fourths_d + 3'h1;
        sevenths_d = 3'h0;
      end else if (press_right && degree_y == degree_seventh) begin // R12
        sevenths_d = sevenths_d + 3'h1;
        fourths_d  = 3'h0;
      end
      if (fourths_d >= streak_len) begin // R13
        key_d      = octave_remainder(key_q + shift_subdom); // R14
        fourths_d  = 3'h0;
        sevenths_d = 3'h0;
      end else if (sevenths_d >= streak_len) begin // R13
        key_d      = octave_remainder(key_q + shift_dominant); // R14
        fourths_d  = 3'h0;
        sevenths_d = 3'h0;
      end
    end else if (update && mode == mode_fixed_key) begin // R15
      key_d      = key_reset;
      fourths_d  = 3'h0;
      sevenths_d = 3'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin // R22
      key_q      <= key_reset;
      fourths_q  <= 3'h0;
      sevenths_q <= 3'h0;
    end else begin
      key_q      <= key_d;
      fourths_q  <= fourths_d;
      sevenths_q <= sevenths_d;
    end
  end

endmodule
`default_nettype wire

// ---- test/pitch_quant_checker_assertions.sv ----
// Port-level assertions for the pointer pitch quantizer.
// Assumes the single clock and the synchronous active-low reset of the top.
`timescale 1ns/10ps
`default_nettype none
module pitch_quant_checker
  import pitch_quant_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        update,
  input wire logic [7:0]  buttons,
  input wire logic [15:0] abs_x,
  input wire logic [15:0] abs_y,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [15:0] pitch_conv_one,
  input wire logic [15:0] pitch_conv_two,
  input wire logic        conv_strobe,
  input wire logic        gate_left,
  input wire logic        gate_right,
  input wire logic        lamp_left_on,
  input wire logic        lamp_right_on
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_pulse;
    conv_strobe ##1 !conv_strobe;
  endsequence
  AST_STROBE: assert property (update ##1 !update |-> s_pulse)
    else $error("converter strobe is not a single cycle after update");
  AST_GATE_L: assert property (update |=> gate_left == $past(buttons[0]))
    else $error("left gate does not follow left button");
  AST_LAMP_L: assert property (update |=>
      lamp_left_on == ($past(buttons[0]) || $past(buttons[2])))
    else $error("left lamp does not follow left or middle button");
  AST_RIGHT: assert property (update |=>
      gate_right == $past(buttons[1]) && lamp_right_on == $past(buttons[1]))
    else $error("right gate or lamp does not follow right button");
  AST_RAW_X: assert property (update && !buttons[0] |=> pitch_conv_one == $past(abs_x))
    else $error("released left button does not give raw x");
  AST_RAW_Y: assert property (update && !buttons[1] |=> pitch_conv_two == $past(abs_y))
    else $error("released right button does not give raw y");
  AST_HOLD: assert property (!update |=> $stable(pitch_conv_one) && $stable(pitch_conv_two))
    else $error("pitch outputs moved without an update");
  AST_READ_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data present without a read");
endmodule
bind pointer_pitch_quantizer pitch_quant_checker chk_u (.clk(clk), .rst_n(rst_n), .update(update),
  .buttons(buttons), .abs_x(abs_x), .abs_y(abs_y), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .pitch_conv_one(pitch_conv_one), .pitch_conv_two(pitch_conv_two), .conv_strobe(conv_strobe),
  .gate_left(gate_left), .gate_right(gate_right), .lamp_left_on(lamp_left_on),
  .lamp_right_on(lamp_right_on));
`default_nettype wire

// ---- test/report_source.sv ----
// Pointer report decoder and pitch converter pair facing the quantizer.
// Assumes send is called from the bench's one stimulus process.
`timescale 1ns/10ps
`default_nettype none
module report_source (
  input  wire logic        clk,
  input  wire logic        conv_strobe,
  input  wire logic [15:0] pitch_conv_one,
  input  wire logic [15:0] pitch_conv_two,
  output logic             update,
  output logic      [7:0]  buttons,
  output logic      [15:0] abs_x,
  output logic      [15:0] abs_y,
  output logic      [15:0] got_one,
  output logic      [15:0] got_two
);
  initial begin
    update  = 1'b0;
    buttons = 8'h00;
    abs_x   = 16'h0000;
    abs_y   = 16'h0000;
  end
  // Converters latch only on the strobe, so a missing strobe shows as stale pitch
  always_ff @(posedge clk) begin
    if (conv_strobe) begin
      got_one <= pitch_conv_one;
      got_two <= pitch_conv_two;
    end
  end
  task automatic send(input logic [7:0] b, input logic [15:0] x, input logic [15:0] y);
    @(posedge clk);
    update  <= 1'b1;
    buttons <= b;
    abs_x   <= x;
    abs_y   <= y;
    @(posedge clk);
    update <= 1'b0;
    // Coordinates are not held outside a report
    abs_x  <= ~x;
    abs_y  <= ~y;
    @(posedge clk);
    #1;
  endtask
endmodule
`default_nettype wire

// ---- test/tb_pointer_pitch_quantizer.sv ----
// Self-checking bench for the pointer pitch quantizer.
// Assumes the report source model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module tb_pointer_pitch_quantizer
  import pitch_quant_pkg::*;
;
  typedef struct packed {
    logic [1:0]  mode;
    logic [7:0]  b;
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] e1;
    logic [15:0] e2;
  } row_type;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        update;
  logic [7:0]  buttons;
  logic [15:0] abs_x;
  logic [15:0] abs_y;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [15:0] conv_one;
  logic [15:0] conv_two;
  logic [15:0] got_one;
  logic [15:0] got_two;
  logic        conv_strobe;
  panel_type   panel;
  int          n_fail = 0;
  int          num_checks = 0;
  row_type     rows [6] = '{
    '{2'h3, 8'h03, 16'h3c40, 16'h1234, 16'h3c40, 16'h1234},
    '{2'h2, 8'h03, 16'h3c80, 16'h3c7f, 16'h3d00, 16'h3c00},
    '{2'h2, 8'h00, 16'h3c80, 16'h3c7f, 16'h3c80, 16'h3c7f},
    '{2'h1, 8'h03, 16'h3d40, 16'h3cc0, 16'h3e00, 16'h3c00},
    '{2'h1, 8'h03, 16'h3a00, 16'h3c00, 16'h3b00, 16'h3c00},
    '{2'h1, 8'h01, 16'h3d40, 16'h3d40, 16'h3e00, 16'h3d40}};
  always #10 clk = ~clk;
  pointer_pitch_quantizer dut_u (.clk(clk), .rst_n(rst_n), .update(update), .buttons(buttons),
    .abs_x(abs_x), .abs_y(abs_y), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pitch_conv_one(conv_one), .pitch_conv_two(conv_two),
    .conv_strobe(conv_strobe), .gate_left(panel.gate_left), .gate_right(panel.gate_right),
    .lamp_left_on(panel.lamp_left_on), .lamp_left_red(panel.lamp_left_red),
    .lamp_right_on(panel.lamp_right_on), .lamp_right_red(panel.lamp_right_red));
  report_source part_u (.clk(clk), .conv_strobe(conv_strobe), .pitch_conv_one(conv_one),
    .pitch_conv_two(conv_two), .update(update), .buttons(buttons), .abs_x(abs_x),
    .abs_y(abs_y), .got_one(got_one), .got_two(got_two));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic check_panel(input logic [7:0] b, input logic [1:0] md);
    check("gate_left", 32'(panel.gate_left), 32'(b[0]));
    check("lamp_left_on", 32'(panel.lamp_left_on), 32'(b[0] | b[2]));
    check("gate_right", 32'(panel.gate_right), 32'(b[1]));
    check("lamp_right_on", 32'(panel.lamp_right_on), 32'(b[1]));
    check("lamp_left_red", 32'(panel.lamp_left_red), 32'(md < 2'h2));
    check("lamp_right_red", 32'(panel.lamp_right_red), 32'(!md[0]));
  endtask
  task automatic complete_run;
    if (n_fail == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    n_fail++;
    complete_run;
  end
  initial begin
    logic [31:0] d;
    logic [1:0]  m;
    logic [15:0] k;
    logic [15:0] p;
    repeat (16) @(posedge clk);
    check("reset panel", 32'(panel), 32'h0);
    rst_n <= 1'b1;
    reg_read(addr_mode, d);
    check("mode", d, 32'h3);
    reg_read(addr_status, d);
    check("status", d, 32'h0);
    reg_read(4'hc, d);
    check("unmapped", d, 32'h0);
    for (int i = 0; i < 6; i++) begin
      reg_write(addr_mode, {30'h0, rows[i].mode});
      part_u.send(rows[i].b, rows[i].x, rows[i].y);
      check("pitch x", 32'(got_one), 32'(rows[i].e1));
      check("pitch y", 32'(got_two), 32'(rows[i].e2));
      check_panel(rows[i].b, rows[i].mode);
    end
    // Middle clicks walk the mode round from fixed key back to fixed key
    m = 2'h1;
    for (int i = 0; i < 4; i++) begin
      m = m + 2'h1;
      part_u.send(8'h04, 16'h3000, 16'h3000);
      check_panel(8'h04, m);
      part_u.send(8'h00, 16'h3000, 16'h3000);
      reg_read(addr_mode, d);
      check("mode", d, {30'h0, m});
    end
    // Sevenths from both sides share one streak; third press shifts key, ninth wraps it
    // Each press plays the seventh of the key expected at that point
    reg_write(addr_mode, 32'h0);
    for (int i = 1; i <= 9; i++) begin
      k = 16'((((i - 1) / 3) * 'h500) % 'hc00);
      p = 16'h3000 + 16'((16'h1700 - k) % 16'hc00);
      part_u.send((i % 2) ? 8'h01 : 8'h02, p, p);
      part_u.send(8'h00, p, p);
      if (i == 1) begin
        reg_read(addr_degrees, d);
        check("degrees", d, 32'h0b0b);
      end
      reg_read(addr_status, d);
      check("status", d,
            (32'(i % 3) << 20) | 32'(((i / 3) * 'h500) % 'hc00));
    end
    part_u.send(8'h01, 16'h3d00, 16'h3000);
    check("pitch x", 32'(got_one), 32'h3d00);
    for (int i = 0; i < 2; i++) begin
      part_u.send(8'h00, 16'h3800, 16'h3800);
      part_u.send(8'h01, 16'h3800, 16'h3800);
    end
    reg_read(addr_status, d);
    check("status", d, 32'h0020_0300);
    reg_write(addr_mode, 32'h1);
    reg_write(addr_status, 32'hffff_ffff);
    part_u.send(8'h00, 16'h3800, 16'h3800);
    reg_read(addr_status, d);
    check("status", d, 32'h0);
    // A seventh, then three fourths: the first fourth clears sevenths, the third shifts key
    reg_write(addr_mode, 32'h0);
    for (int i = 0; i < 4; i++) begin
      part_u.send(8'h01, (i == 0) ? 16'h3b00 : 16'h3500, 16'h3000);
      part_u.send(8'h00, 16'h3000, 16'h3000);
      reg_read(addr_status, d);
      check("status", d,
            (i == 0) ? 32'h0010_0000 : (i == 3) ? 32'h0000_0700 : 32'(i) << 16);
    end
    complete_run;
  end
endmodule
`default_nettype wire
